// >>> admc_pkg.sv
// constants and field layout of the audio converter mode control block
// How it works
// R1: host shifts 16-bit words then pulses latch
// R2: msb first, sampled on rising program clock
// R3: address 10 mute/format, 11 interface config
// R4: mute bit ramps output down to silence
// R5: bit 1 turns de-emphasis on or off
// R6: operation disable forces bipolar zero always
// R7: enabled: convert data, zeros per detector
// R8: 65536 zero bit clocks force bipolar zero
// R9: detector off means no automatic muting
// R10: forced bipolar zero disconnects the modulator
// R11: reset pin low forces zero, ignores port
// R12: word length 16, 20 or 24 bits
// R13: per channel route mute, right, left, average
// R14: lower bit is the pair code msb
// R15: format bit selects right-justified or i2s
// R16: polarity bit swaps word clock channel meaning
// R17: attenuator link uses left value for both
// R18: rate group 44.1, 48 or 32 kHz
// R19: bit 8 enables zero detect, 5-3 reserved
// R20: latency is a fixed 11.125 sample periods
// R21: eight times interpolation, 48 or 64 fs
// R22: third order shaper, five level quantizer
// R23: defined defaults after reset
package admc_pkg;
  // ****************************************
  // control word layout
  // ****************************************
  localparam int CW_BITS = 16;
  localparam int ADDR_HI_POS = 10;
  localparam int ADDR_LO_POS = 9;
  localparam logic [1:0] ADDR_MFC = 2'h2;
  localparam logic [1:0] ADDR_IFC = 2'h3;
  localparam int REG_W = 9;
  // ****************************************
  // field positions
  // ****************************************
  localparam int MUTE_POS = 0;
  localparam int DEEMPH_POS = 1;
  localparam int OPDIS_POS = 2;
  localparam int WL_LO_POS = 3;
  localparam int WL_HI_POS = 4;
  localparam int ROUTE_0_POS = 5;
  localparam int ROUTE_1_POS = 6;
  localparam int ROUTE_2_POS = 7;
  localparam int ROUTE_3_POS = 8;
  localparam int FMT_POS = 0;
  localparam int POL_POS = 1;
  localparam int LINK_POS = 2;
  localparam int RATE_LO_POS = 6;
  localparam int RATE_HI_POS = 7;
  localparam int ZDET_POS = 8;
  // ****************************************
  // reset values and encodings
  // ****************************************
  localparam logic [8:0] MFC_RST = 9'h120;
  localparam logic [8:0] IFC_RST = 9'h000;
  localparam logic [8:0] IFC_RSVD_MASK = 9'h038;
  // strap flops start at 384 fs so the ratio output cannot dip after reset
  localparam logic [6:0] SYNC_RST = 7'h40;
  localparam logic [1:0] WL_16 = 2'h0;
  localparam logic [1:0] WL_20 = 2'h1;
  localparam logic [1:0] WL_24 = 2'h2;
  localparam logic [1:0] RT_MUTE = 2'h0;
  localparam logic [1:0] RT_RIGHT = 2'h1;
  localparam logic [1:0] RT_LEFT = 2'h2;
  localparam logic [1:0] RT_AVG = 2'h3;
  // ****************************************
  // audio and modulator figures
  // ****************************************
  localparam int SMP_W = 24;
  localparam int ACC_W = 28;
  localparam int Q_SHIFT = 22;
  localparam logic [2:0] BPZ_CODE = 3'h2;
  localparam int ZERO_RUN_DEFAULT = 65536;
  localparam int ZCNT_W = 17;
  localparam logic [8:0] GAIN_FULL = 9'h100;
  localparam logic [6:0] OSR_384 = 7'h30;
  localparam logic [6:0] OSR_256 = 7'h40;
  localparam logic [7:0] LATENCY_EIGHTHS = 8'h59;
  localparam logic [4:0] BITCNT_MAX = 5'h1F;
endpackage : admc_pkg

// >>> admc_ctrl_port.sv
// three-wire program port: shifts control words and commits them
`timescale 1ns/10ps
module admc_ctrl_port
  import admc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic prog_clk_s,
  input wire logic prog_data_s,
  input wire logic prog_latch_s,
  output logic word_valid,
  output logic [CW_BITS-1:0] word
);
  logic clk_prev;
  logic latch_prev;
  logic [CW_BITS-1:0] shreg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clk_prev <= 1'b0;
      latch_prev <= 1'b0;
    end else begin
      clk_prev <= prog_clk_s;
      latch_prev <= prog_latch_s;
    end
  end

  // only the last sixteen bits before the latch count
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shreg <= '0;
    end else if (!enable) begin
      shreg <= '0;
    end else if (prog_clk_s && !clk_prev) begin
      shreg <= {shreg[CW_BITS-2:0], prog_data_s}; // R2
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      word_valid <= 1'b0;
      word <= '0;
    end else begin
      word_valid <= enable && prog_latch_s && !latch_prev; // R1
      if (enable && prog_latch_s && !latch_prev) begin
        word <= shreg;
      end
    end
  end
endmodule : admc_ctrl_port

// >>> admc_modulator.sv
// third-order error-feedback modulator with a five-level quantizer
`timescale 1ns/10ps
module admc_modulator
  import admc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic [SMP_W-1:0] sample,
  output logic [2:0] code
);
  logic signed [ACC_W-1:0] e1;
  logic signed [ACC_W-1:0] e2;
  logic signed [ACC_W-1:0] e3;
  logic signed [ACC_W-1:0] u;
  logic signed [ACC_W-1:0] qfull;
  logic signed [2:0] q;
  logic signed [ACC_W-1:0] next_e;

  // loop filter gives (1 - z^-1)^3 noise shaping
  always_comb begin
    u = ACC_W'(ACC_W'($signed(sample)) + 3 * e1 - 3 * e2 + e3); // R22
    qfull = (u + (ACC_W'(1) <<< (Q_SHIFT - 1))) >>> Q_SHIFT;
    if (qfull > 2) begin
      q = 3'sh2;
    end else if (qfull < -2) begin
      q = -3'sh2;
    end else begin
      q = qfull[2:0];
    end
    next_e = u - (ACC_W'(q) <<< Q_SHIFT);
  end

  // clear drops the shaper state so an unmute starts cleanly
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      e1 <= '0;
      e2 <= '0;
      e3 <= '0;
      code <= BPZ_CODE;
    end else if (clear) begin
      e1 <= '0;
      e2 <= '0;
      e3 <= '0;
      code <= BPZ_CODE;
    end else begin
      e1 <= next_e;
      e2 <= e1;
      e3 <= e2;
      code <= 3'(q + 3'sh2); // R22
    end
  end
endmodule : admc_modulator

// >>> admc_top.sv
// mode registers, serial audio receiver and output control
`timescale 1ns/10ps
module admc_top
  import admc_pkg::*;
#(
  parameter int ZERO_RUN_BITS = ZERO_RUN_DEFAULT
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reset_n_pin,
  input wire logic program_clock,
  input wire logic program_data,
  input wire logic program_latch,
  input wire logic bit_clock_in,
  input wire logic word_clock_in,
  input wire logic audio_data_in,
  input wire logic sysclk_is_384,
  output logic [2:0] dac_code_l,
  output logic [2:0] dac_code_r,
  output logic modulator_connected,
  output logic deemphasis_enable,
  output logic attenuator_link,
  output logic [1:0] rate_group,
  output logic [1:0] word_length,
  output logic [6:0] mod_oversample,
  output logic [7:0] latency_eighths
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  localparam int NPIN = 7;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1;
  logic [NPIN-1:0] sync2;

  assign pin_raw = {sysclk_is_384, audio_data_in, word_clock_in,
                    bit_clock_in, program_latch, program_data,
                    program_clock};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          sync1[gi] <= SYNC_RST[gi];
          sync2[gi] <= SYNC_RST[gi];
        end else begin
          sync1[gi] <= pin_raw[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  logic pclk_s;
  logic pdata_s;
  logic platch_s;
  logic bck_s;
  logic wck_s;
  logic din_s;
  logic sys384_s;
  logic rst_pin_s;
  logic rst_sync1;

  assign pclk_s = sync2[0];
  assign pdata_s = sync2[1];
  assign platch_s = sync2[2];
  assign bck_s = sync2[3];
  assign wck_s = sync2[4];
  assign din_s = sync2[5];
  assign sys384_s = sync2[6];

  // device reset pin is held low until it is seen high twice
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rst_sync1 <= 1'b0;
      rst_pin_s <= 1'b0;
    end else begin
      rst_sync1 <= reset_n_pin;
      rst_pin_s <= rst_sync1;
    end
  end

  // ****************************************
  // control port and mode registers
  // ****************************************
  logic cw_valid;
  logic [CW_BITS-1:0] cw;
  logic [REG_W-1:0] mute_format_control;
  logic [REG_W-1:0] interface_configuration;
  logic [1:0] cw_addr;

  admc_ctrl_port u_port (
    .core_clk(core_clk),
    .rst(rst),
    .enable(rst_pin_s), // R11
    .prog_clk_s(pclk_s),
    .prog_data_s(pdata_s),
    .prog_latch_s(platch_s),
    .word_valid(cw_valid),
    .word(cw)
  );

  assign cw_addr = {cw[ADDR_HI_POS], cw[ADDR_LO_POS]};

  // attenuation addresses are taken and dropped here
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mute_format_control <= MFC_RST; // R23
      interface_configuration <= IFC_RST; // R23
    end else if (!rst_pin_s) begin
      mute_format_control <= MFC_RST; // R11
      interface_configuration <= IFC_RST; // R11
    end else if (cw_valid) begin
      if (cw_addr == ADDR_MFC) begin
        mute_format_control <= cw[REG_W-1:0]; // R3
      end
      if (cw_addr == ADDR_IFC) begin
        interface_configuration <= cw[REG_W-1:0] & ~IFC_RSVD_MASK; // R3 R19
      end
    end
  end

  logic soft_mute;
  logic op_disable;
  logic fmt_i2s;
  logic wck_polarity;
  logic zero_detect_enable;
  logic [1:0] route_left;
  logic [1:0] route_right;
  logic [1:0] wl_code;

  assign soft_mute = mute_format_control[MUTE_POS]; // R4
  assign op_disable = mute_format_control[OPDIS_POS]; // R6
  assign wl_code = {mute_format_control[WL_HI_POS],
                    mute_format_control[WL_LO_POS]}; // R12
  assign route_left = {mute_format_control[ROUTE_0_POS],
                       mute_format_control[ROUTE_1_POS]}; // R14
  assign route_right = {mute_format_control[ROUTE_2_POS],
                        mute_format_control[ROUTE_3_POS]}; // R14
  assign fmt_i2s = interface_configuration[FMT_POS]; // R15
  assign wck_polarity = interface_configuration[POL_POS]; // R16
  assign zero_detect_enable = interface_configuration[ZDET_POS]; // R19

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      deemphasis_enable <= 1'b0;
      attenuator_link <= 1'b0;
      rate_group <= 2'h0;
      word_length <= WL_16;
      mod_oversample <= OSR_384;
      latency_eighths <= LATENCY_EIGHTHS;
    end else begin
      deemphasis_enable <= mute_format_control[DEEMPH_POS]; // R5
      attenuator_link <= interface_configuration[LINK_POS]; // R17
      rate_group <= {interface_configuration[RATE_HI_POS],
                     interface_configuration[RATE_LO_POS]}; // R18
      word_length <= wl_code;
      mod_oversample <= sys384_s ? OSR_384 : OSR_256; // R21
      latency_eighths <= LATENCY_EIGHTHS; // R20
    end
  end

  // ****************************************
  // serial audio receiver
  // ****************************************
  logic bck_prev;
  logic bck_rise;
  logic wck_last;
  logic frame_edge;
  logic [4:0] bit_cnt;
  logic [SMP_W-1:0] shreg;
  logic [4:0] wl_bits;
  logic take_bit;
  logic [SMP_W-1:0] smp_l;
  logic [SMP_W-1:0] smp_r;
  logic frame_tick;

  // reserved word length falls back to sixteen bits
  always_comb begin
    case (wl_code)
      WL_20: wl_bits = 5'h14;
      WL_24: wl_bits = 5'h18;
      default: wl_bits = 5'h10;
    endcase
  end

  // left-justify so every length uses the full scale
  function automatic logic [SMP_W-1:0] align(
    input logic [SMP_W-1:0] raw,
    input logic [1:0] wl
  );
    case (wl)
      WL_20: align = {raw[19:0], 4'h0};
      WL_24: align = raw;
      default: align = {raw[15:0], 8'h00};
    endcase
  endfunction : align

  assign bck_rise = bck_s && !bck_prev;
  assign frame_edge = bck_rise && (wck_s != wck_last);
  // i2s skips one bit after the edge, then takes the word
  assign take_bit = !fmt_i2s ||
                    (bit_cnt >= 5'h01 && bit_cnt <= wl_bits); // R15

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bck_prev <= 1'b0;
      wck_last <= 1'b0;
      bit_cnt <= 5'h0;
      shreg <= '0;
    end else begin
      bck_prev <= bck_s;
      if (frame_edge) begin
        wck_last <= wck_s;
        bit_cnt <= 5'h1;
        shreg <= fmt_i2s ? '0 : {shreg[SMP_W-2:0], din_s};
      end else if (bck_rise) begin
        if (bit_cnt != BITCNT_MAX) begin
          bit_cnt <= bit_cnt + 5'h1;
        end
        if (take_bit) begin
          shreg <= {shreg[SMP_W-2:0], din_s};
        end
      end
    end
  end

  // the half that just ended tells the channel
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      smp_l <= '0;
      smp_r <= '0;
      frame_tick <= 1'b0;
    end else begin
      frame_tick <= 1'b0;
      if (frame_edge) begin
        if (wck_last ^ wck_polarity) begin // R16
          smp_l <= align(shreg, wl_code); // R12
        end else begin
          smp_r <= align(shreg, wl_code);
          frame_tick <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // zero run detector
  // ****************************************
  logic [ZCNT_W-1:0] zcnt;
  logic zero_hit;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      zcnt <= '0;
    end else if (bck_rise) begin
      if (din_s) begin
        zcnt <= '0;
      end else if (zcnt != ZCNT_W'(ZERO_RUN_BITS)) begin
        zcnt <= zcnt + ZCNT_W'(1); // R8
      end
    end
  end

  assign zero_hit = (zcnt == ZCNT_W'(ZERO_RUN_BITS)); // R8

  // ****************************************
  // routing and soft mute
  // ****************************************
  logic [SMP_W-1:0] avg;
  logic [SMP_W-1:0] rout_l;
  logic [SMP_W-1:0] rout_r;
  logic [8:0] gain;

  function automatic logic [SMP_W-1:0] pick(
    input logic [1:0] sel,
    input logic [SMP_W-1:0] l,
    input logic [SMP_W-1:0] r,
    input logic [SMP_W-1:0] a
  );
    case (sel)
      RT_RIGHT: pick = r;
      RT_LEFT: pick = l;
      RT_AVG: pick = a;
      default: pick = '0;
    endcase
  endfunction : pick

  logic signed [SMP_W:0] sum_lr;
  assign sum_lr = $signed({smp_l[SMP_W-1], smp_l}) +
                  $signed({smp_r[SMP_W-1], smp_r});
  assign avg = sum_lr[SMP_W:1]; // R13
  assign rout_l = pick(route_left, smp_l, smp_r, avg); // R13
  assign rout_r = pick(route_right, smp_l, smp_r, avg); // R13

  // one step per frame: the ramp lasts 256 frames, no click
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gain <= GAIN_FULL;
    end else if (frame_tick) begin
      if (soft_mute && gain != 9'h000) begin
        gain <= gain - 9'h001; // R4
      end else if (!soft_mute && gain != GAIN_FULL) begin
        gain <= gain + 9'h001;
      end
    end
  end

  logic signed [SMP_W+9:0] prod_l;
  logic signed [SMP_W+9:0] prod_r;
  assign prod_l = $signed(rout_l) * $signed({1'b0, gain});
  assign prod_r = $signed(rout_r) * $signed({1'b0, gain});

  // ****************************************
  // bipolar zero forcing and modulators
  // ****************************************
  logic force_bpz;
  logic [2:0] code_l;
  logic [2:0] code_r;

  // detector off: zero input simply flows through the modulator
  assign force_bpz = !rst_pin_s || op_disable || // R6 R7 R11
                     (zero_detect_enable && zero_hit); // R8 R9

  admc_modulator u_mod_l (
    .core_clk(core_clk),
    .rst(rst),
    .clear(force_bpz),
    .sample(prod_l[SMP_W+7:8]),
    .code(code_l)
  );

  admc_modulator u_mod_r (
    .core_clk(core_clk),
    .rst(rst),
    .clear(force_bpz),
    .sample(prod_r[SMP_W+7:8]),
    .code(code_r)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dac_code_l <= BPZ_CODE;
      dac_code_r <= BPZ_CODE;
      modulator_connected <= 1'b0;
    end else begin
      dac_code_l <= force_bpz ? BPZ_CODE : code_l; // R6
      dac_code_r <= force_bpz ? BPZ_CODE : code_r; // R6
      modulator_connected <= !force_bpz; // R10
    end
  end
endmodule : admc_top

// >>> admc_top_chk.sv
// assertion checker bound to the mode control top level
`timescale 1ns/10ps
module admc_top_chk
  import admc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reset_n_pin,
  input wire logic program_latch,
  input wire logic sysclk_is_384,
  input wire logic [2:0] dac_code_l,
  input wire logic [2:0] dac_code_r,
  input wire logic modulator_connected,
  input wire logic deemphasis_enable,
  input wire logic attenuator_link,
  input wire logic [1:0] rate_group,
  input wire logic [1:0] word_length,
  input wire logic [6:0] mod_oversample,
  input wire logic [7:0] latency_eighths
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic bipolar_zero;
  assign bipolar_zero = (dac_code_l == BPZ_CODE) && (dac_code_r == BPZ_CODE);
  property p_disc;
    !modulator_connected |-> bipolar_zero;
  endproperty
  a_disc: assert property (p_disc)
    else $error("outputs off bipolar zero while disconnected");
  property p_pin;
    !reset_n_pin [*5] |-> bipolar_zero && !modulator_connected;
  endproperty
  a_pin: assert property (p_pin)
    else $error("outputs not forced while reset pin low");
  property p_pin_dflt;
    !reset_n_pin [*5] |-> word_length == WL_16 && !deemphasis_enable
      && !attenuator_link && rate_group == 2'h0;
  endproperty
  a_pin_dflt: assert property (p_pin_dflt)
    else $error("settings not at defaults while reset pin low");
  property p_rst_dflt;
    $fell(rst) |-> word_length == WL_16 && rate_group == 2'h0
      && !deemphasis_enable && !attenuator_link && !modulator_connected;
  endproperty
  a_rst_dflt: assert property (p_rst_dflt)
    else $error("settings not at defaults after reset");
  property p_osr;
    mod_oversample == ($past(sysclk_is_384, 3) ? 7'h30 : 7'h40);
  endproperty
  a_osr: assert property (p_osr)
    else $error("oversampling figure does not follow the strap");
  property p_lat;
    latency_eighths == 8'h59;
  endproperty
  a_lat: assert property (p_lat)
    else $error("latency figure wrong");
  property p_lvl;
    dac_code_l <= 3'h4 && dac_code_r <= 3'h4;
  endproperty
  a_lvl: assert property (p_lvl)
    else $error("output code beyond five levels");
  // a commit must not show up in the first cycles after the latch edge
  property p_hold;
    $rose(program_latch) |=> ($stable(word_length) && $stable(rate_group)
      && $stable(deemphasis_enable)) [*3];
  endproperty
  a_hold: assert property (p_hold)
    else $error("setting changed too early after latch");
  property p_cause;
    $changed(deemphasis_enable) |-> $past(program_latch, 4)
      || !$past(reset_n_pin, 2) || !$past(reset_n_pin, 3);
  endproperty
  a_cause: assert property (p_cause)
    else $error("setting changed without a latched write");
  c_forced: cover property (reset_n_pin && !modulator_connected);
  c_wl24: cover property (word_length == WL_24);
  c_link: cover property (attenuator_link && rate_group == 2'h1);
endmodule : admc_top_chk

bind admc_top admc_top_chk chk_i (
  .core_clk(core_clk), .rst(rst), .reset_n_pin(reset_n_pin),
  .program_latch(program_latch), .sysclk_is_384(sysclk_is_384),
  .dac_code_l(dac_code_l), .dac_code_r(dac_code_r),
  .modulator_connected(modulator_connected),
  .deemphasis_enable(deemphasis_enable),
  .attenuator_link(attenuator_link), .rate_group(rate_group),
  .word_length(word_length), .mod_oversample(mod_oversample),
  .latency_eighths(latency_eighths)
);

// >>> admc_src_model.sv
// host program port and serial audio source model
`timescale 1ns/10ps
module admc_src_model (
  output logic program_clock,
  output logic program_data,
  output logic program_latch,
  output logic bit_clock_in,
  output logic word_clock_in,
  output logic audio_data_in,
  input wire logic [31:0] left_smp,
  input wire logic [31:0] right_smp
);
  logic [31:0] sh;
  int n;
  // each phase 160 ns, above the three core clocks the port needs
  task automatic write_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      program_data = w[i];
      #160 program_clock = 1'b1;
      #160 program_clock = 1'b0;
    end
    #160 program_latch = 1'b1;
    #160 program_latch = 1'b0;
    program_data = ~w[0];
  endtask : write_word
  // 32-bit halves, right-justified; word clock high carries left
  initial begin
    program_clock = 1'b0;
    program_data = 1'b0;
    program_latch = 1'b0;
    bit_clock_in = 1'b1;
    word_clock_in = 1'b0;
    audio_data_in = 1'b0;
    sh = '0;
    n = 0;
    #37;
    forever begin
      #160 bit_clock_in = 1'b0;
      if (n == 0) begin
        word_clock_in = ~word_clock_in;
        sh = word_clock_in ? left_smp : right_smp;
      end
      audio_data_in = sh[31];
      sh = sh << 1;
      n = (n + 1) % 32;
      #160 bit_clock_in = 1'b1;
    end
  end
endmodule : admc_src_model

// >>> admc_tb_top.sv
// self-checking bench for the mode control block
`timescale 1ns/10ps
module admc_tb_top;
  import admc_pkg::*;
  typedef struct packed {
    logic [15:0] w;
    logic [5:0] e;
  } admc_row_s;
  logic core_clk, rst, reset_n_pin, sysclk_is_384;
  logic program_clock, program_data, program_latch;
  logic bit_clock_in, word_clock_in, audio_data_in;
  logic [31:0] left_smp, right_smp;
  logic [2:0] dac_code_l, dac_code_r;
  logic modulator_connected, deemphasis_enable, attenuator_link;
  logic [1:0] rate_group, word_length;
  logic [6:0] mod_oversample;
  logic [7:0] latency_eighths;
  int num_errors, compares;
  // expected {deemphasis, link, rate group, word length} after each write
  admc_row_s rows [7] = '{{16'h0532, 6'h22}, {16'h0644, 6'h36},
    {16'h0528, 6'h15}, {16'h06B8, 6'h09}, {16'h0220, 6'h09},
    {16'hFD38, 6'h0B}, {16'h07C0, 6'h0F}};

  admc_top #(.ZERO_RUN_BITS(64)) dut (
    .core_clk(core_clk), .rst(rst), .reset_n_pin(reset_n_pin),
    .program_clock(program_clock), .program_data(program_data),
    .program_latch(program_latch), .bit_clock_in(bit_clock_in),
    .word_clock_in(word_clock_in), .audio_data_in(audio_data_in),
    .sysclk_is_384(sysclk_is_384), .dac_code_l(dac_code_l),
    .dac_code_r(dac_code_r), .modulator_connected(modulator_connected),
    .deemphasis_enable(deemphasis_enable),
    .attenuator_link(attenuator_link), .rate_group(rate_group),
    .word_length(word_length), .mod_oversample(mod_oversample),
    .latency_eighths(latency_eighths)
  );
  admc_src_model src (
    .program_clock(program_clock), .program_data(program_data),
    .program_latch(program_latch), .bit_clock_in(bit_clock_in),
    .word_clock_in(word_clock_in), .audio_data_in(audio_data_in),
    .left_smp(left_smp), .right_smp(right_smp)
  );

  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;

  task automatic end_sim();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [15:0] seen,
                     input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wait_neg(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wait_neg

  task automatic wr(input logic [15:0] w);
    src.write_word(w);
    wait_neg(12);
  endtask : wr

  initial begin
    #1000000;
    num_errors++;
    end_sim();
  end

  initial begin
    rst = 1'b1;
    reset_n_pin = 1'b1;
    sysclk_is_384 = 1'b1;
    left_smp = 32'h00005A5B;
    right_smp = 32'h00003C3D;
    num_errors = 0;
    compares = 0;
    wait_neg(10);
    chk("rst_codes", {dac_code_l, dac_code_r, modulator_connected},
        7'h24);
    chk("rst_cfg", {deemphasis_enable, attenuator_link, rate_group,
        word_length}, 6'h00);
    chk("rst_osr", mod_oversample, 7'h30);
    wait_neg(10);
    rst = 1'b0;
    wait_neg(8);
    foreach (rows[i]) begin
      wr(rows[i].w);
      chk("cfg", {deemphasis_enable, attenuator_link, rate_group,
          word_length}, rows[i].e);
    end
    chk("conn_run", modulator_connected, 1'b1);
    // zeros with detection on: still live before the count ends
    left_smp = '0;
    right_smp = '0;
    wait_neg(320);
    chk("conn_early", modulator_connected, 1'b1);
    wait_neg(800);
    chk("conn_zero", modulator_connected, 1'b0);
    chk("code_zero", dac_code_l, BPZ_CODE);
    wr(16'h0600);
    chk("conn_nodet", modulator_connected, 1'b1);
    left_smp = 32'h00005A5B;
    right_smp = 32'h00003C3D;
    wr(16'h0524);
    chk("opdis_conn", modulator_connected, 1'b0);
    chk("opdis_code", dac_code_r, BPZ_CODE);
    wr(16'h0400);
    chk("mute_route", {dac_code_l, dac_code_r, modulator_connected},
        7'h25);
    wr(16'h0520);
    chk("open_conn", modulator_connected, 1'b1);
    wr(16'h0532);
    reset_n_pin = 1'b0;
    wait_neg(8);
    chk("pin_out", {dac_code_l, dac_code_r, modulator_connected},
        7'h24);
    chk("pin_cfg", {deemphasis_enable, word_length}, 3'h0);
    wr(16'h0532);
    reset_n_pin = 1'b1;
    wait_neg(12);
    chk("pin_ign", {deemphasis_enable, word_length}, 3'h0);
    chk("pin_conn", modulator_connected, 1'b1);
    sysclk_is_384 = 1'b0;
    wait_neg(4);
    chk("osr256", mod_oversample, 7'h40);
    sysclk_is_384 = 1'b1;
    wait_neg(4);
    chk("osr384", mod_oversample, 7'h30);
    chk("latency", latency_eighths, 8'h59);
    end_sim();
  end
endmodule : admc_tb_top
